// >>> verilog/window_watchdog_timer.sv
`timescale 1ns/1ps
module window_watchdog_timer #(
  parameter int TICK_DIV = watchdog_pkg::TICK_DIV_DEFAULT,
  parameter int ADDR_W = 12
) (
  input wire logic clk_in, // divided oscillator clock, 100 MHz
  input wire logic rst_in, // synchronous device reset, active high
  input wire logic hw_watchdog_opt_in, // option: watchdog always active
  input wire logic halt_reset_option_in, // option: halt gives a reset
  input wire logic timebase_irq_enable_in, // selects active halt
  input wire logic wake_delay_long_in, // resume delay 4096 instead of 256
  input wire logic halt_req_in, // pulse: halt instruction executed
  input wire logic ext_irq_in, // pulse: external wake interrupt
  input wire logic osc_irq_in, // pulse: oscillator interrupt
  input wire logic wake_reset_in, // pulse: reset that ends a halt mode
  output logic wdg_reset_out, // pulse: watchdog device reset request
  output logic halted_out, // level: counter not in normal run
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in, // write address
  input wire logic s_axi_awvalid_in, // write address valid
  output logic s_axi_awready_out, // write address ready
  input wire logic [watchdog_pkg::DATA_W-1:0] s_axi_wdata_in, // write data
  input wire logic [3:0] s_axi_wstrb_in, // write byte strobes
  input wire logic s_axi_wvalid_in, // write data valid
  output logic s_axi_wready_out, // write data ready
  output logic [watchdog_pkg::RESP_W-1:0] s_axi_bresp_out, // write response
  output logic s_axi_bvalid_out, // write response valid
  input wire logic s_axi_bready_in, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr_in, // read address
  input wire logic s_axi_arvalid_in, // read address valid
  output logic s_axi_arready_out, // read address ready
  output logic [watchdog_pkg::DATA_W-1:0] s_axi_rdata_out, // read data
  output logic [watchdog_pkg::RESP_W-1:0] s_axi_rresp_out, // read response
  output logic s_axi_rvalid_out, // read data valid
  input wire logic s_axi_rready_in // read data ready
);
  import watchdog_pkg::*;

  if (ADDR_W < 10)
  begin : g_chk
    $error("window_watchdog_timer: ADDR_W must be at least 10");
  end

  function automatic logic hits(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hits = (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  endfunction

  // ---------------- bus slave ----------------
  logic awready_q;
  logic wready_q;
  logic aw_have_q;
  logic w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [DATA_W-1:0] w_data_q;
  logic w_lane0_q;
  logic bvalid_q;
  logic [RESP_W-1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [RESP_W-1:0] rresp_q;
  logic do_wr;
  logic ctl_wr;
  logic win_wr;

  assign do_wr = aw_have_q && w_have_q && !bvalid_q;
  assign ctl_wr = do_wr && w_lane0_q && hits(aw_addr_q, CTRL_IDX);
  assign win_wr = do_wr && w_lane0_q && hits(aw_addr_q, WIN_IDX);

  // address and data are taken independently; both stay closed until the response
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_lane0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_in && awready_q)
      begin
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
        aw_addr_q <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && wready_q)
      begin
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
        w_data_q <= s_axi_wdata_in;
        w_lane0_q <= s_axi_wstrb_in[0];
      end
      if (do_wr)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (hits(aw_addr_q, CTRL_IDX) || hits(aw_addr_q, WIN_IDX)) ?
                   RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready_in)
      begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // ---------------- watchdog core ----------------
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] win_q;
  logic act_q;
  logic wdg_rst_q;
  logic halted_q;
  power_state_t st_q;
  power_state_t st_d;
  logic [DLY_W-1:0] dly_q;
  logic [DLY_W-1:0] dly_d;
  logic active;
  logic new_act;
  logic dec;
  logic halt_rst_drop;
  logic fire;
  tick_link_if link ();

  tick_prescaler #(
    .DIV(TICK_DIV)
  ) u_prescaler (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .link(link)
  );

  // counter timebase is clk_in, not the processor clock, so slow and wait
  // modes cannot change its rate
  assign link.run = (st_q == ST_RUN) || (st_q == ST_HALT_ONCE);
  assign dec = link.tick;
  assign active = act_q || hw_watchdog_opt_in;
  assign new_act = active || w_data_q[ACT_BIT];
  assign halt_rst_drop = wake_reset_in &&
                         ((st_q == ST_HALT_ONCE) || (st_q == ST_HALT_STOP));

  assign fire = (dec && (st_q == ST_RUN) && active && (cnt_q == ROLL_VALUE))
             || (ctl_wr && new_act && !w_data_q[TOP_BIT])
             || (ctl_wr && new_act && (cnt_q > win_q))
             || ((st_q == ST_RUN) && halt_req_in && !timebase_irq_enable_in
                 && halt_reset_option_in && active);

  always_comb
  begin
    st_d = st_q;
    dly_d = dly_q;
    case (st_q)
      ST_RUN:
      begin
        if (halt_req_in && timebase_irq_enable_in)
          st_d = ST_ACT_HALT;
        else if (halt_req_in && !halt_reset_option_in)
          st_d = ST_HALT_ONCE;
      end
      ST_HALT_ONCE:
      begin
        if (wake_reset_in)
          st_d = ST_RUN;
        else if (ext_irq_in)
          st_d = ST_RESUME;
        else if (dec)
          st_d = ST_HALT_STOP;
      end
      ST_HALT_STOP:
      begin
        if (wake_reset_in)
          st_d = ST_RUN;
        else if (ext_irq_in)
          st_d = ST_RESUME;
      end
      ST_ACT_HALT:
      begin
        if (wake_reset_in)
          st_d = ST_RESUME;
        else if (ext_irq_in || osc_irq_in)
          st_d = ST_RUN;
      end
      ST_RESUME:
      begin
        if (dly_q == '0)
          st_d = ST_RUN;
        else
          dly_d = dly_q - DLY_W'(1);
      end
      default:
        st_d = ST_RUN;
    endcase
    if ((st_d == ST_RESUME) && (st_q != ST_RESUME))
      dly_d = wake_delay_long_in ? DLY_W'(DLY_LONG - 1) : DLY_W'(DLY_SHORT - 1);
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      st_q <= ST_RUN;
      dly_q <= '0;
      halted_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      dly_q <= dly_d;
      halted_q <= (st_d != ST_RUN);
    end
  end

  // live counter: a reload wins over a decrement in the same cycle
  always_ff @(posedge clk_in)
  begin
    if (rst_in || halt_rst_drop)
      cnt_q <= CNT_RESET;
    else if (ctl_wr)
      cnt_q <= w_data_q[CNT_W-1:0];
    else if (dec)
      cnt_q <= cnt_q - CNT_W'(1);
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in || halt_rst_drop)
      act_q <= 1'b0;
    else if (ctl_wr && w_data_q[ACT_BIT])
      act_q <= 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      win_q <= WIN_RESET;
    else if (win_wr)
      win_q <= w_data_q[CNT_W-1:0];
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      wdg_rst_q <= 1'b0;
    else
      wdg_rst_q <= fire;
  end

  // ---------------- read channel ----------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end
    else if (s_axi_arvalid_in && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      if (hits(s_axi_araddr_in, CTRL_IDX))
        rdata_q <= {24'h00_0000, act_q, cnt_q};
      else if (hits(s_axi_araddr_in, WIN_IDX))
        rdata_q <= {24'h00_0000, 1'b0, win_q};
      else
      begin
        rdata_q <= '0;
        rresp_q <= RESP_SLVERR;
      end
    end
    else if (rvalid_q && s_axi_rready_in)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready_out = awready_q;
  assign s_axi_wready_out = wready_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_arready_out = arready_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;
  assign wdg_reset_out = wdg_rst_q;
  assign halted_out = halted_q;

  // ---------------- checks ----------------
  a_roll_reset: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (dec && st_q == ST_RUN && active && cnt_q == ROLL_VALUE) |=> wdg_reset_out)
    else $error("roll from 40h did not reset");

  a_early_refresh: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (ctl_wr && active && cnt_q > win_q) |=> wdg_reset_out)
    else $error("early refresh did not reset");

  a_soft_reset: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (ctl_wr && w_data_q[ACT_BIT] && !w_data_q[TOP_BIT]) |=> wdg_reset_out)
    else $error("software reset missing");

  a_disabled_quiet: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (!active && !(ctl_wr && w_data_q[ACT_BIT])) |=> !wdg_reset_out)
    else $error("reset while disabled");

  a_act_sticky: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (act_q && !wake_reset_in) |=> act_q)
    else $error("activation bit cleared without reset");

  a_count_step: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (dec && !ctl_wr && !halt_rst_drop) |=> (cnt_q == $past(cnt_q) - 7'h01))
    else $error("counter did not decrement");

  a_halt_stopped: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ((st_q == ST_HALT_STOP || st_q == ST_ACT_HALT) && !wake_reset_in && !ctl_wr)
    |=> $stable(cnt_q) && !wdg_reset_out)
    else $error("counter moved in halt");

  a_halt_reset: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (st_q == ST_RUN && halt_req_in && !timebase_irq_enable_in
     && halt_reset_option_in && active) |=> wdg_reset_out && st_q == ST_RUN)
    else $error("halt did not reset");

  a_active_halt: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (st_q == ST_RUN && halt_req_in && timebase_irq_enable_in) |=> st_q == ST_ACT_HALT)
    else $error("active halt not entered");

  a_active_wake: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (st_q == ST_ACT_HALT && (osc_irq_in || ext_irq_in) && !wake_reset_in) |=> st_q == ST_RUN)
    else $error("active halt did not wake at once");

  a_short_resume: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (st_d == ST_RESUME && st_q != ST_RESUME && !wake_delay_long_in)
    |-> ##256 st_q == ST_RESUME ##1 st_q == ST_RUN)
    else $error("resume delay wrong");

  a_halt_drop: assert property (
    @(posedge clk_in) disable iff (rst_in)
    halt_rst_drop |=> !act_q && cnt_q == CNT_RESET && (active == hw_watchdog_opt_in))
    else $error("reset from halt did not restore state");
endmodule

// >>> verilog/watchdog_pkg.sv
package watchdog_pkg;

  localparam int DATA_W = 32;
  localparam int RESP_W = 2;
  localparam int CNT_W = 7;

  // printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] CTRL_IDX = 8'h2f;
  localparam logic [7:0] WIN_IDX = 8'h30;

  localparam int ACT_BIT = 7;
  localparam int TOP_BIT = 6;

  localparam logic [CNT_W-1:0] CNT_RESET = 7'h7f;
  localparam logic [CNT_W-1:0] WIN_RESET = 7'h7f;
  localparam logic [CNT_W-1:0] ROLL_VALUE = 7'h40;

  localparam int TICK_DIV_DEFAULT = 16384;
  localparam int DLY_SHORT = 256;
  localparam int DLY_LONG = 4096;
  localparam int DLY_W = 12;

  localparam logic [RESP_W-1:0] RESP_OKAY = 2'h0;
  localparam logic [RESP_W-1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_HALT_ONCE,
    ST_HALT_STOP,
    ST_ACT_HALT,
    ST_RESUME
  } power_state_t;

endpackage

// >>> verilog/tick_link_if.sv
`timescale 1ns/1ps
interface tick_link_if;
  logic run;
  logic tick;

  modport source (input run, output tick);
  modport sink (output run, input tick);
endinterface

// >>> verilog/tick_prescaler.sv
`timescale 1ns/1ps
module tick_prescaler #(
  parameter int DIV = 16384
) (
  input wire logic clk_in, // divided oscillator clock
  input wire logic rst_in, // synchronous reset, active high
  tick_link_if.source link // run request in, tick pulse out
);
  localparam int PW = $clog2(DIV);
  localparam logic [PW-1:0] LAST = PW'(DIV - 1);

  logic [PW-1:0] pre_q;

  if (DIV < 2)
  begin : g_chk
    $error("tick_prescaler: DIV must be at least 2");
  end

  // prescaler is never cleared by a register write, so the first period after
  // a reload is shorter by an unknown amount
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      pre_q <= '0;
    else if (link.run)
      pre_q <= (pre_q == LAST) ? '0 : pre_q + PW'(1);
  end

  // tick is gated by run so that no late step lands in a state that just stopped
  assign link.tick = link.run && (pre_q == LAST);
endmodule

// >>> dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import watchdog_pkg::*;
  localparam logic [11:0] A_CTRL = {2'b00, CTRL_IDX, 2'b00};
  localparam logic [11:0] A_WIN = {2'b00, WIN_IDX, 2'b00};
  logic clk, rst, hw_opt, halt_opt, irq_en, dly_long;
  logic halt_req, ext_irq, osc_irq, wake_rst, wdg_rst, halted;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, ra;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, last_resp;
  logic [31:0] seed;
  int n_mismatch, tests_run, n_pulse, p0;

  window_watchdog_timer #(.TICK_DIV(8), .ADDR_W(12)) window_watchdog_timer_inst (
    .clk_in(clk), .rst_in(rst), .hw_watchdog_opt_in(hw_opt),
    .halt_reset_option_in(halt_opt), .timebase_irq_enable_in(irq_en),
    .wake_delay_long_in(dly_long), .halt_req_in(halt_req), .ext_irq_in(ext_irq),
    .osc_irq_in(osc_irq), .wake_reset_in(wake_rst), .wdg_reset_out(wdg_rst),
    .halted_out(halted), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready)
  );

  always #5 clk = ~clk;

  // reset requests are counted here so short pulses are never missed
  always @(posedge clk)
    if (rst)
      n_pulse <= 0;
    else if (wdg_rst === 1'b1)
      n_pulse <= n_pulse + 1;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // window keeps only its low seven bits
  function automatic logic [31:0] win_exp(input logic [31:0] d);
    return {25'h0, d[6:0]};
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic pcheck(input string nm, input int e);
    chk(nm, e, n_pulse - p0);
    p0 = n_pulse;
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      t++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (!(bvalid === 1'b1) && t < 100);
    last_resp = bresp;
    if (t >= 100)
      chk("write answer", 1, 0);
  endtask

  task automatic axi_rd(input logic [11:0] a);
    int t;
    t = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      t++;
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (!(rvalid === 1'b1) && t < 100);
    rd = rdata;
    last_resp = rresp;
    if (t >= 100)
      chk("read answer", 1, 0);
  endtask

  task automatic pulse(input int k);
    case (k)
      0: halt_req <= 1'b1;
      1: ext_irq <= 1'b1;
      2: osc_irq <= 1'b1;
      default: wake_rst <= 1'b1;
    endcase
    @(posedge clk);
    {halt_req, ext_irq, osc_irq, wake_rst} <= 4'h0;
  endtask

  task automatic do_reset(input int n);
    rst <= 1'b1;
    step(n);
    rst <= 1'b0;
    p0 = 0;
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    n_mismatch++;
    test_done();
  end

  initial
  begin
    clk = 0; rst = 1; hw_opt = 0; halt_opt = 0; irq_en = 0; dly_long = 0;
    halt_req = 0; ext_irq = 0; osc_irq = 0; wake_rst = 0; awaddr = 0; araddr = 0;
    wdata = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    seed = 32'h0cfb_9082; n_mismatch = 0; tests_run = 0; p0 = 0;
    do_reset(16);
    axi_rd(A_CTRL);
    chk("control reset", 32'h0000_007f, rd);
    axi_rd(A_WIN);
    chk("window reset", 32'h0000_007f, rd);
    axi_rd(12'h100);
    chk("unmapped read", 32'h0000_0000, rd);
    chk("unmapped read resp", RESP_SLVERR, last_resp);
    axi_wr(12'h104, 32'h0000_0055);
    chk("unmapped write resp", RESP_SLVERR, last_resp);
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      axi_wr(A_WIN, seed);
      axi_rd(A_WIN);
      chk("window readback", win_exp(seed), rd);
    end
    axi_wr(A_WIN, 32'h0000_007f);
    $display("test registers done");
    axi_rd(A_CTRL);
    ra = rd;
    step(80);
    axi_rd(A_CTRL);
    chk("free run drop", 1, (ra - rd >= 9) && (ra - rd <= 11));
    axi_wr(A_CTRL, 32'h0000_0041);
    step(100);
    pcheck("roll while disabled", 0);
    $display("test free run done");
    axi_wr(A_CTRL, 32'h0000_00c1);
    step(40);
    pcheck("roll reset", 1);
    axi_wr(A_CTRL, 32'h0000_007f);
    axi_rd(A_CTRL);
    chk("activation sticky", 32'h0000_0080, rd & 32'h0000_0080);
    axi_wr(A_CTRL, 32'h0000_00bf);
    step(4);
    pcheck("software reset", 1);
    axi_wr(A_CTRL, 32'h0000_00c6);
    axi_wr(A_WIN, 32'h0000_0050);
    axi_wr(A_CTRL, 32'h0000_00ff);
    step(4);
    pcheck("refresh inside window", 0);
    axi_wr(A_CTRL, 32'h0000_00ff);
    step(4);
    pcheck("early refresh", 1);
    axi_wr(A_WIN, 32'h0000_007f);
    $display("test window done");
    do_reset(2);
    hw_opt <= 1'b1;
    axi_wr(A_CTRL, 32'h0000_0041);
    step(40);
    pcheck("hardware option roll", 1);
    hw_opt <= 1'b0;
    do_reset(2);
    axi_wr(A_CTRL, 32'h0000_00ff);
    halt_opt <= 1'b1;
    pulse(0);
    step(4);
    pcheck("halt reset option", 1);
    chk("no halt entry", 0, halted);
    halt_opt <= 1'b0;
    axi_wr(A_CTRL, 32'h0000_00c2);
    pulse(0);
    step(3);
    chk("halt entered", 1, halted);
    step(17);
    axi_rd(A_CTRL);
    ra = rd;
    step(200);
    axi_rd(A_CTRL);
    chk("halt frozen", ra, rd);
    pcheck("no reset in halt", 0);
    pulse(1);
    step(250);
    chk("short resume wait", 1, halted);
    step(12);
    chk("short resume end", 0, halted);
    step(40);
    pcheck("roll after wake", 1);
    pulse(0);
    step(3);
    pulse(3);
    step(4);
    axi_rd(A_CTRL);
    chk("halt reset clears act", 0, rd[7]);
    chk("halt reset runs", 0, halted);
    $display("test halt done");
    irq_en <= 1'b1;
    pulse(0);
    step(3);
    chk("active halt entered", 1, halted);
    axi_rd(A_CTRL);
    ra = rd;
    step(100);
    axi_rd(A_CTRL);
    chk("active halt frozen", ra, rd);
    pulse(2);
    step(3);
    chk("osc wake at once", 0, halted);
    pulse(0);
    step(3);
    chk("active halt again", 1, halted);
    pulse(1);
    step(3);
    chk("ext wake at once", 0, halted);
    dly_long <= 1'b1;
    pulse(0);
    step(3);
    pulse(3);
    step(4088);
    chk("long resume wait", 1, halted);
    step(14);
    chk("long resume end", 0, halted);
    irq_en <= 1'b0;
    $display("test active halt done");
    test_done();
  end
endmodule
